// >>> rtl/tde_pkg.sv
// Constants and types shared by the tap detection engine
//
// Overview of operation
// - Tap candidate only above programmed tap threshold
// - Above-threshold excursion limited by tap max duration
// - Latency wait after first tap before window
// - Second tap must start inside window only
// - Single-only: single flag on fall within duration
// - Both enabled: single flag after double resolved
// - Suppress: spike during latency cancels double tap
// - Above threshold at window open rejects double
// - Overlong second tap rejects double at limit
// - Enable bits select single, double or both
// - Per-axis bits select participating axes
// - First triggering axis recorded, overwritten only
// - Improved mode uses filtered ac-coupled difference
// - Striking positive face gives negative sign
// - Output rates decimated; plain taps use raw
// - Sign bit 1 negative; involved bit 1
// - Signs update on events, enabled axes only
package tde_pkg;
  localparam logic [5:0] ADDR_TAP_THRESHOLD       = 6'h1D;
  localparam logic [5:0] ADDR_TAP_MAX_DURATION    = 6'h21;
  localparam logic [5:0] ADDR_TAP_LATENCY_TIME    = 6'h22;
  localparam logic [5:0] ADDR_SECOND_TAP_WINDOW   = 6'h23;
  localparam logic [5:0] ADDR_TAP_AXIS_CONTROL    = 6'h2A;
  localparam logic [5:0] ADDR_MOTION_EVENT_STATUS = 6'h2B;
  localparam logic [5:0] ADDR_OUTPUT_RATE_CONTROL = 6'h2C;
  localparam logic [5:0] ADDR_IRQ_ENABLE_MASK     = 6'h2E;
  localparam logic [5:0] ADDR_IRQ_SOURCE_FLAGS    = 6'h30;
  localparam logic [5:0] ADDR_TAP_SIGN_STATUS     = 6'h3A;
  localparam int AXIS_Z_BIT     = 0;
  localparam int AXIS_Y_BIT     = 1;
  localparam int AXIS_X_BIT     = 2;
  localparam int SUPPRESS_BIT   = 3;
  localparam int IMPROVED_BIT   = 4;
  localparam int IRQ_DOUBLE_BIT = 5;
  localparam int IRQ_SINGLE_BIT = 6;
  localparam int SIGN_LSB       = 4;
  localparam logic [7:0] RST_REG_ZERO  = 8'h00;
  localparam logic [7:0] RST_RATE_CTRL = 8'h0A;
  localparam logic [3:0] RATE_MAX_CODE = 4'hF;
  // Internal sample period and register time steps
  localparam int SAMPLE_PERIOD_NS = 312500;
  localparam int DUR_LSB_NS       = 625000;
  localparam int LAT_LSB_NS       = 1250000;
  localparam int WIN_LSB_NS       = 1250000;
  localparam logic [15:0] DUR_TICKS = 16'(DUR_LSB_NS / SAMPLE_PERIOD_NS);
  localparam logic [15:0] LAT_TICKS = 16'(LAT_LSB_NS / SAMPLE_PERIOD_NS);
  localparam logic [15:0] WIN_TICKS = 16'(WIN_LSB_NS / SAMPLE_PERIOD_NS);
  localparam int FILT_SHIFT = 2;
  typedef enum logic [5:0] {
    S_IDLE    = 6'h01,
    S_TAP1    = 6'h02,
    S_LAT     = 6'h04,
    S_WIN     = 6'h08,
    S_TAP2    = 6'h10,
    S_WAITLOW = 6'h20
  } tde_state_t;
endpackage : tde_pkg

// >>> rtl/tde_smp_if.sv
// Output-rate sample bus from the decimator to the detector
interface tde_smp_if #(parameter int DATA_W = 13);
  logic                     stb;
  logic [15:0]              step;
  logic signed [DATA_W-1:0] d [3];
  modport src (output stb, output step, output d);
  modport dst (input stb, input step, input d);
endinterface : tde_smp_if

// >>> rtl/tde_axis.sv
// Per-axis threshold comparator with optional ac-coupled difference
module tde_axis
  import tde_pkg::*;
#(
  parameter int DATA_W    = 13,
  parameter int THR_SHIFT = 4
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  input  wire logic                     stb,
  input  wire logic                     improved,
  input  wire logic signed [DATA_W-1:0] sample,
  input  wire logic [7:0]               thr,
  output logic                          above,
  output logic                          neg
);
  logic signed [DATA_W-1:0] prev_reg;
  logic signed [DATA_W-1:0] prev_next;
  logic signed [DATA_W:0]   val;
  logic [DATA_W:0]          mag;

  always_comb begin
    prev_next = (ce && stb) ? sample : prev_reg;
    // Improved mode looks at the sample-to-sample change
    if (improved) begin
      val = {sample[DATA_W-1], sample} - {prev_reg[DATA_W-1], prev_reg};
    end else begin
      val = {sample[DATA_W-1], sample};
    end
    mag   = val[DATA_W] ? (DATA_W+1)'(-val) : val;
    above = (mag >> THR_SHIFT) > (DATA_W+1)'(thr);
    neg   = val[DATA_W];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= prev_next;
    end
  end
endmodule : tde_axis

// >>> rtl/tde_decim.sv
// Decimating low-pass path that makes the output-rate samples
module tde_decim
  import tde_pkg::*;
#(
  parameter int DATA_W = 13
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  input  wire logic                     standby,
  input  wire logic                     raw_stb,
  input  wire logic signed [DATA_W-1:0] raw [3],
  input  wire logic [3:0]               rate,
  tde_smp_if.src                        output_sample_rate
);
  logic signed [DATA_W-1:0] filt_reg [3];
  logic signed [DATA_W-1:0] filt_next [3];
  logic signed [DATA_W-1:0] out_reg [3];
  logic signed [DATA_W-1:0] out_next [3];
  logic [15:0]              div_reg;
  logic [15:0]              div_next;
  logic [15:0]              step_reg;
  logic [15:0]              step_next;
  logic                     stb_reg;
  logic                     stb_next;
  logic signed [DATA_W:0]   diff;
  logic signed [DATA_W:0]   sum;

  always_comb begin
    step_next = 16'h0001 << (RATE_MAX_CODE - rate);
    div_next  = div_reg;
    stb_next  = 1'b0;
    diff      = '0;
    sum       = '0;
    for (int a = 0; a < 3; a++) begin
      filt_next[a] = filt_reg[a];
      out_next[a]  = out_reg[a];
    end
    if (ce && standby) begin
      div_next = '0;
    end else if (ce && raw_stb) begin
      for (int a = 0; a < 3; a++) begin
        diff = {raw[a][DATA_W-1], raw[a]} - {filt_reg[a][DATA_W-1], filt_reg[a]};
        sum  = {filt_reg[a][DATA_W-1], filt_reg[a]} + (diff >>> FILT_SHIFT);
        filt_next[a] = sum[DATA_W-1:0];
      end
      if (div_reg + 16'h0001 >= step_next) begin
        div_next = '0;
        stb_next = 1'b1;
        out_next = filt_next;
      end else begin
        div_next = div_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_reg <= '{default: '0};
      out_reg  <= '{default: '0};
      div_reg  <= '0;
      step_reg <= 16'h0001;
      stb_reg  <= 1'b0;
    end else begin
      filt_reg <= filt_next;
      out_reg  <= out_next;
      div_reg  <= div_next;
      step_reg <= ce ? step_next : step_reg;
      stb_reg  <= ce ? stb_next : stb_reg;
    end
  end

  assign output_sample_rate.stb  = stb_reg;
  assign output_sample_rate.step = step_reg;
  assign output_sample_rate.d    = out_reg;
endmodule : tde_decim

// >>> rtl/tde_top.sv
// Tap detection engine: registers, tap sequencer and status
module tde_top
  import tde_pkg::*;
#(
  parameter int DATA_W    = 13,
  parameter int THR_SHIFT = 4
) (
  // Clock and reset
  input  wire logic                     CLK_SYS_IN,
  input  wire logic                     RESET_N_IN,
  input  wire logic                     CLK_EN_IN,
  input  wire logic                     STANDBY_IN,
  // Raw samples at the internal rate
  input  wire logic                     SAMPLE_STB_IN,
  input  wire logic signed [DATA_W-1:0] ACC_X_IN,
  input  wire logic signed [DATA_W-1:0] ACC_Y_IN,
  input  wire logic signed [DATA_W-1:0] ACC_Z_IN,
  // Register port from the serial engine
  input  wire logic [5:0]               REG_ADDR_IN,
  input  wire logic                     REG_WR_IN,
  input  wire logic [7:0]               REG_WDATA_IN,
  input  wire logic                     REG_RD_IN,
  output logic [7:0]                    REG_RDATA_OUT,
  // Event flags
  output logic                          SINGLE_TAP_FLAG_OUT,
  output logic                          DOUBLE_TAP_FLAG_OUT
);
  if (DATA_W < 9 || THR_SHIFT < 0 || THR_SHIFT > DATA_W) begin : g_bad_param
    $error("tde_top: DATA_W or THR_SHIFT out of range");
  end

  tde_smp_if #(.DATA_W(DATA_W)) odr_bus ();

  logic signed [DATA_W-1:0] raw [3];
  logic signed [DATA_W-1:0] sel [3];
  logic [2:0]               above_vec;
  logic [2:0]               neg_vec;
  logic                     improved;
  logic                     tick;
  logic [15:0]              step;

  // Register file state
  logic [7:0] thr_reg, thr_next;
  logic [7:0] dur_reg, dur_next;
  logic [7:0] lat_reg, lat_next;
  logic [7:0] win_reg, win_next;
  logic [7:0] axes_reg, axes_next;
  logic [7:0] rate_reg, rate_next;
  logic [7:0] ien_reg, ien_next;
  logic       sflag_reg, sflag_next;
  logic       dflag_reg, dflag_next;
  logic [2:0] inv_reg, inv_next;
  logic [2:0] sgn_reg, sgn_next;
  logic [7:0] rdata_reg, rdata_next;

  // Sequencer state
  tde_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [2:0]  first_inv_reg, first_inv_next;
  logic [2:0]  cap_sgn_reg, cap_sgn_next;
  logic        single_ev;
  logic        double_ev;

  logic [2:0]  axis_en;
  logic [2:0]  above_en;
  logic        any_above;
  logic [2:0]  pick_inv;
  logic [16:0] cnt_sum;
  logic [15:0] cnt_inc;
  logic [15:0] dur_lim;
  logic [15:0] lat_lim;
  logic [15:0] win_lim;
  logic        st_en;
  logic        dt_en;
  logic        src_read;

  assign raw[0] = ACC_X_IN;
  assign raw[1] = ACC_Y_IN;
  assign raw[2] = ACC_Z_IN;

  tde_decim #(.DATA_W(DATA_W)) u_decim (
    .clk     (CLK_SYS_IN),
    .rst_n   (RESET_N_IN),
    .ce      (CLK_EN_IN),
    .standby (STANDBY_IN),
    .raw_stb (SAMPLE_STB_IN),
    .raw     (raw),
    .rate    (rate_reg[3:0]),
    .output_sample_rate     (odr_bus.src)
  );

  // Plain taps use raw samples, improved taps the output-rate ones
  assign improved = axes_reg[IMPROVED_BIT];
  assign tick     = improved ? odr_bus.stb : SAMPLE_STB_IN;
  assign step     = improved ? odr_bus.step : 16'h0001;

  for (genvar a = 0; a < 3; a++) begin : g_axis
    assign sel[a] = improved ? odr_bus.d[a] : raw[a];
    tde_axis #(.DATA_W(DATA_W), .THR_SHIFT(THR_SHIFT)) u_axis (
      .clk      (CLK_SYS_IN),
      .rst_n    (RESET_N_IN),
      .ce       (CLK_EN_IN),
      .stb      (tick),
      .improved (improved),
      .sample   (sel[a]),
      .thr      (thr_reg),
      .above    (above_vec[a]),
      .neg      (neg_vec[a])
    );
  end

  // Tap sequencer
  always_comb begin
    axis_en   = {axes_reg[AXIS_Z_BIT], axes_reg[AXIS_Y_BIT], axes_reg[AXIS_X_BIT]};
    above_en  = above_vec & axis_en;
    any_above = |above_en;
    pick_inv  = {above_en[0], above_en[1] & ~above_en[0], above_en[2] & ~|above_en[1:0]};
    st_en     = ien_reg[IRQ_SINGLE_BIT];
    dt_en     = ien_reg[IRQ_DOUBLE_BIT];
    dur_lim   = 16'(dur_reg) * DUR_TICKS;
    lat_lim   = 16'(lat_reg) * LAT_TICKS;
    win_lim   = 16'(win_reg) * WIN_TICKS;
    cnt_sum   = {1'b0, cnt_reg} + {1'b0, step};
    cnt_inc   = cnt_sum[16] ? 16'hFFFF : cnt_sum[15:0];
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    first_inv_next = first_inv_reg;
    cap_sgn_next   = cap_sgn_reg;
    single_ev      = 1'b0;
    double_ev      = 1'b0;
    if (CLK_EN_IN && STANDBY_IN) begin
      state_next = S_IDLE;
      cnt_next   = '0;
    end else if (CLK_EN_IN && tick) begin
      case (state_reg)
        S_IDLE: begin
          if (any_above && (st_en || dt_en)) begin
            state_next     = S_TAP1;
            cnt_next       = step;
            first_inv_next = pick_inv;
            cap_sgn_next   = {neg_vec[0], neg_vec[1], neg_vec[2]};
          end
        end
        S_TAP1: begin
          if (!any_above) begin
            if (dt_en && lat_reg != 8'h00 && win_reg != 8'h00) begin
              state_next = S_LAT;
              cnt_next   = '0;
            end else begin
              single_ev  = st_en;
              state_next = S_IDLE;
            end
          end else if (cnt_reg >= dur_lim) begin
            state_next = S_WAITLOW;
          end else begin
            cnt_next = cnt_inc;
          end
        end
        S_LAT: begin
          if (axes_reg[SUPPRESS_BIT] && any_above) begin
            single_ev  = st_en;
            state_next = S_WAITLOW;
          end else if (cnt_inc >= lat_lim) begin
            if (any_above) begin
              single_ev  = st_en;
              state_next = S_WAITLOW;
            end else begin
              state_next = S_WIN;
              cnt_next   = '0;
            end
          end else begin
            cnt_next = cnt_inc;
          end
        end
        S_WIN: begin
          if (any_above) begin
            state_next = S_TAP2;
            cnt_next   = step;
          end else if (cnt_inc >= win_lim) begin
            single_ev  = st_en;
            state_next = S_IDLE;
          end else begin
            cnt_next = cnt_inc;
          end
        end
        S_TAP2: begin
          if (!any_above) begin
            single_ev  = st_en;
            double_ev  = dt_en;
            state_next = S_IDLE;
          end else if (cnt_reg >= dur_lim) begin
            single_ev  = st_en;
            state_next = S_WAITLOW;
          end else begin
            cnt_next = cnt_inc;
          end
        end
        S_WAITLOW: begin
          if (!any_above) begin
            state_next = S_IDLE;
          end
        end
        default: begin
          state_next = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_reg     <= S_IDLE;
      cnt_reg       <= '0;
      first_inv_reg <= '0;
      cap_sgn_reg   <= '0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      first_inv_reg <= first_inv_next;
      cap_sgn_reg   <= cap_sgn_next;
    end
  end

  // Register file, status capture and read-to-clear flags
  always_comb begin
    thr_next   = thr_reg;
    dur_next   = dur_reg;
    lat_next   = lat_reg;
    win_next   = win_reg;
    axes_next  = axes_reg;
    rate_next  = rate_reg;
    ien_next   = ien_reg;
    inv_next   = inv_reg;
    sgn_next   = sgn_reg;
    rdata_next = rdata_reg;
    src_read   = CLK_EN_IN && REG_RD_IN && REG_ADDR_IN == ADDR_IRQ_SOURCE_FLAGS;
    sflag_next = src_read ? 1'b0 : sflag_reg;
    dflag_next = src_read ? 1'b0 : dflag_reg;
    if (single_ev) begin
      sflag_next = 1'b1;
    end
    if (double_ev) begin
      dflag_next = 1'b1;
    end
    if (single_ev || double_ev) begin
      inv_next = first_inv_reg;
      for (int b = 0; b < 3; b++) begin
        if (axes_reg[b]) begin
          sgn_next[b] = cap_sgn_reg[b];
        end
      end
    end
    if (CLK_EN_IN && REG_WR_IN) begin
      if (REG_ADDR_IN == ADDR_TAP_THRESHOLD) begin
        thr_next = REG_WDATA_IN;
      end else if (REG_ADDR_IN == ADDR_TAP_MAX_DURATION) begin
        dur_next = REG_WDATA_IN;
      end else if (REG_ADDR_IN == ADDR_TAP_LATENCY_TIME) begin
        lat_next = REG_WDATA_IN;
      end else if (REG_ADDR_IN == ADDR_SECOND_TAP_WINDOW) begin
        win_next = REG_WDATA_IN;
      end else if (REG_ADDR_IN == ADDR_TAP_AXIS_CONTROL) begin
        axes_next = REG_WDATA_IN;
      end else if (REG_ADDR_IN == ADDR_OUTPUT_RATE_CONTROL) begin
        rate_next = REG_WDATA_IN;
      end else if (REG_ADDR_IN == ADDR_IRQ_ENABLE_MASK) begin
        ien_next = REG_WDATA_IN;
      end
    end
    if (CLK_EN_IN && REG_RD_IN) begin
      if (REG_ADDR_IN == ADDR_TAP_THRESHOLD) begin
        rdata_next = thr_reg;
      end else if (REG_ADDR_IN == ADDR_TAP_MAX_DURATION) begin
        rdata_next = dur_reg;
      end else if (REG_ADDR_IN == ADDR_TAP_LATENCY_TIME) begin
        rdata_next = lat_reg;
      end else if (REG_ADDR_IN == ADDR_SECOND_TAP_WINDOW) begin
        rdata_next = win_reg;
      end else if (REG_ADDR_IN == ADDR_TAP_AXIS_CONTROL) begin
        rdata_next = axes_reg;
      end else if (REG_ADDR_IN == ADDR_MOTION_EVENT_STATUS) begin
        rdata_next = {5'h00, inv_reg};
      end else if (REG_ADDR_IN == ADDR_OUTPUT_RATE_CONTROL) begin
        rdata_next = rate_reg;
      end else if (REG_ADDR_IN == ADDR_IRQ_ENABLE_MASK) begin
        rdata_next = ien_reg;
      end else if (REG_ADDR_IN == ADDR_IRQ_SOURCE_FLAGS) begin
        rdata_next = {1'b0, sflag_reg, dflag_reg, 5'h00};
      end else if (REG_ADDR_IN == ADDR_TAP_SIGN_STATUS) begin
        rdata_next = {1'b0, sgn_reg, 1'b0, inv_reg};
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      thr_reg   <= RST_REG_ZERO;
      dur_reg   <= RST_REG_ZERO;
      lat_reg   <= RST_REG_ZERO;
      win_reg   <= RST_REG_ZERO;
      axes_reg  <= RST_REG_ZERO;
      rate_reg  <= RST_RATE_CTRL;
      ien_reg   <= RST_REG_ZERO;
      sflag_reg <= 1'b0;
      dflag_reg <= 1'b0;
      inv_reg   <= '0;
      sgn_reg   <= '0;
      rdata_reg <= RST_REG_ZERO;
    end else begin
      thr_reg   <= thr_next;
      dur_reg   <= dur_next;
      lat_reg   <= lat_next;
      win_reg   <= win_next;
      axes_reg  <= axes_next;
      rate_reg  <= rate_next;
      ien_reg   <= ien_next;
      sflag_reg <= sflag_next;
      dflag_reg <= dflag_next;
      inv_reg   <= inv_next;
      sgn_reg   <= sgn_next;
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA_OUT       = rdata_reg;
  assign SINGLE_TAP_FLAG_OUT = sflag_reg;
  assign DOUBLE_TAP_FLAG_OUT = dflag_reg;

  // Checks
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESET_N_IN);

  property p_idle_needs_above;
    CLK_EN_IN && tick && !STANDBY_IN && state_reg == S_IDLE && above_en == 3'b000
      |=> state_reg == S_IDLE;
  endproperty
  a_idle_needs_above: assert property (p_idle_needs_above) else $error("tap started below threshold");
  property p_axis_gate;
    CLK_EN_IN && tick && !STANDBY_IN && state_reg == S_IDLE && (above_vec & ~axis_en) != 0
      && (above_vec & axis_en) == 0 |=> state_reg == S_IDLE;
  endproperty
  a_axis_gate: assert property (p_axis_gate) else $error("disabled axis started a tap");
  property p_single_only;
    CLK_EN_IN && tick && !STANDBY_IN && state_reg == S_TAP1 && !any_above && st_en && !dt_en
      |-> single_ev ##1 sflag_reg;
  endproperty
  a_single_only: assert property (p_single_only) else $error("single tap not flagged");
  property p_single_waits;
    single_ev && dt_en && lat_reg != 8'h00 && win_reg != 8'h00 |-> state_reg != S_TAP1;
  endproperty
  a_single_waits: assert property (p_single_waits) else $error("single flagged before double");
  property p_suppress;
    CLK_EN_IN && tick && !STANDBY_IN && state_reg == S_LAT && axes_reg[SUPPRESS_BIT] && any_above
      |=> state_reg == S_WAITLOW ##1 !dflag_reg || $past(dflag_reg);
  endproperty
  a_suppress: assert property (p_suppress) else $error("suppress did not cancel");
  property p_lat_end;
    state_reg == S_LAT ##1 state_reg == S_WIN |-> $past(cnt_inc) >= lat_lim;
  endproperty
  a_lat_end: assert property (p_lat_end) else $error("window opened early");
  property p_win_second;
    CLK_EN_IN && tick && !STANDBY_IN && state_reg == S_WIN && any_above |=> state_reg == S_TAP2;
  endproperty
  a_win_second: assert property (p_win_second) else $error("second tap missed in window");
  property p_long_second;
    CLK_EN_IN && tick && !STANDBY_IN && state_reg == S_TAP2 && any_above && cnt_reg >= dur_lim
      |-> !double_ev ##1 state_reg == S_WAITLOW;
  endproperty
  a_long_second: assert property (p_long_second) else $error("overlong second tap accepted");
  property p_status;
    single_ev || double_ev |=> inv_reg == $past(first_inv_reg);
  endproperty
  a_status: assert property (p_status) else $error("first axis not recorded");
  property p_flag_hold;
    sflag_reg && !src_read |=> sflag_reg;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("single flag lost without read");
  property p_flag_clear;
    src_read && !single_ev && !double_ev |=> !sflag_reg && !dflag_reg;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("read did not clear flags");
  property p_enable;
    $rose(dflag_reg) |-> $past(dt_en);
  endproperty
  a_enable: assert property (p_enable) else $error("double flag while disabled");

  c_single: cover property (single_ev && !dt_en);
  c_double: cover property (double_ev);
  c_suppress: cover property (state_reg == S_LAT ##1 state_reg == S_WAITLOW);
  c_improved: cover property (improved && state_reg == S_TAP1);
endmodule : tde_top

// >>> testbench/tde_host_model.sv
// Host processor model driving the byte register port
module tde_host_model (
  // Clock
  input  wire logic       clk_in,
  // Register port
  input  wire logic [7:0] reg_rdata_in,
  output logic [5:0]      reg_addr_out,
  output logic            reg_wr_out,
  output logic [7:0]      reg_wdata_out,
  output logic            reg_rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr_out  = 6'h00;
    reg_wr_out    = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out    = 1'b0;
  end
  // Released address and data show the inverse of the last value
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_addr_out  = a;
    reg_wdata_out = d;
    reg_wr_out    = 1'b1;
    @(negedge clk_in);
    reg_wr_out    = 1'b0;
    reg_addr_out  = ~a;
    reg_wdata_out = ~d;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk_in);
    reg_addr_out = a;
    reg_rd_out   = 1'b1;
    @(negedge clk_in);
    reg_rd_out   = 1'b0;
    reg_addr_out = ~a;
    @(negedge clk_in);
    d = reg_rdata_in;
  endtask : rd
endmodule : tde_host_model

// >>> testbench/tde_top_bench.sv
// Self-checking bench for the tap detection engine
module tde_top_bench
  import tde_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic signed [12:0] HI = 13'sh0400;
  localparam logic signed [12:0] NG = 13'sh1C00;
  localparam logic signed [12:0] LO = 13'sh0000;
  logic               clk;
  logic               rst_n;
  logic               stb;
  logic signed [12:0] ax;
  logic signed [12:0] ay;
  logic signed [12:0] az;
  logic [5:0]         addr;
  logic               wr;
  logic [7:0]         wdata;
  logic               rd;
  logic [7:0]         rdata;
  logic               sflag;
  logic               dflag;
  logic [7:0]         v;
  int                 mismatches = 0;
  int                 compares = 0;
  int                 cycles = 0;
  tde_top dut (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .CLK_EN_IN(1'b1), .STANDBY_IN(1'b0),
    .SAMPLE_STB_IN(stb), .ACC_X_IN(ax), .ACC_Y_IN(ay), .ACC_Z_IN(az), .REG_ADDR_IN(addr),
    .REG_WR_IN(wr), .REG_WDATA_IN(wdata), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .SINGLE_TAP_FLAG_OUT(sflag), .DOUBLE_TAP_FLAG_OUT(dflag));
  tde_host_model host (.clk_in(clk), .reg_rdata_in(rdata), .reg_addr_out(addr),
    .reg_wr_out(wr), .reg_wdata_out(wdata), .reg_rd_out(rd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  // One sample per four cycles
  task automatic tick(input logic signed [12:0] x, y, z, input int n);
    repeat (n) begin
      @(negedge clk);
      {ax, ay, az, stb} = {x, y, z, 1'b1};
      @(negedge clk);
      stb = 1'b0;
      repeat (2) @(negedge clk);
    end
  endtask : tick
  task automatic flags(input logic s, input logic d, input logic [7:0] src);
    chk("single", {7'h00, sflag}, {7'h00, s});
    chk("double", {7'h00, dflag}, {7'h00, d});
    host.rd(ADDR_IRQ_SOURCE_FLAGS, v);
    chk("source", v, src);
    chk("cleared", {6'h00, sflag, dflag}, 8'h00);
  endtask : flags
  task automatic t_regs();
    host.rd(ADDR_OUTPUT_RATE_CONTROL, v);
    chk("rate", v, RST_RATE_CTRL);
    host.rd(ADDR_TAP_THRESHOLD, v);
    chk("thr rst", v, RST_REG_ZERO);
    host.wr(ADDR_TAP_THRESHOLD, 8'h10);
    host.rd(ADDR_TAP_THRESHOLD, v);
    chk("thr", v, 8'h10);
    host.rd(6'h3F, v);
    chk("unmapped", v, 8'h00);
  endtask : t_regs
  task automatic t_single();
    host.wr(ADDR_TAP_MAX_DURATION, 8'h01);
    host.wr(ADDR_TAP_AXIS_CONTROL, 8'h07);
    host.wr(ADDR_IRQ_ENABLE_MASK, 8'h40);
    tick(NG, LO, LO, 2);
    tick(LO, LO, LO, 1);
    flags(1'b1, 1'b0, 8'h40);
    host.rd(ADDR_MOTION_EVENT_STATUS, v);
    chk("status", v, 8'h04);
    host.rd(ADDR_TAP_SIGN_STATUS, v);
    chk("sign", v, 8'h44);
  endtask : t_single
  task automatic t_reject();
    tick(HI, LO, LO, 3);
    tick(LO, LO, LO, 1);
    flags(1'b0, 1'b0, 8'h00);
    host.wr(ADDR_TAP_AXIS_CONTROL, 8'h01);
    tick(HI, LO, LO, 1);
    tick(LO, LO, LO, 1);
    flags(1'b0, 1'b0, 8'h00);
  endtask : t_reject
  task automatic t_double();
    host.wr(ADDR_TAP_LATENCY_TIME, 8'h01);
    host.wr(ADDR_SECOND_TAP_WINDOW, 8'h02);
    host.wr(ADDR_IRQ_ENABLE_MASK, 8'h60);
    tick(LO, LO, HI, 1);
    tick(LO, LO, LO, 6);
    tick(LO, LO, HI, 1);
    tick(LO, LO, LO, 1);
    flags(1'b1, 1'b1, 8'h60);
    host.rd(ADDR_MOTION_EVENT_STATUS, v);
    chk("status z", v, 8'h01);
    host.wr(ADDR_TAP_AXIS_CONTROL, 8'h09);
    tick(LO, LO, HI, 1);
    tick(LO, LO, LO, 2);
    tick(LO, LO, HI, 1);
    tick(LO, LO, LO, 12);
    flags(1'b1, 1'b0, 8'h40);
  endtask : t_double
  task automatic t_improved();
    host.wr(ADDR_IRQ_ENABLE_MASK, 8'h40);
    host.wr(ADDR_TAP_MAX_DURATION, 8'h08);
    host.wr(ADDR_TAP_THRESHOLD, 8'h04);
    host.wr(ADDR_OUTPUT_RATE_CONTROL, 8'h0F);
    host.wr(ADDR_TAP_AXIS_CONTROL, 8'h14);
    tick(HI, LO, LO, 6);
    flags(1'b1, 1'b0, 8'h40);
    host.rd(ADDR_TAP_SIGN_STATUS, v);
    chk("improved sign", v, 8'h04);
  endtask : t_improved
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    {rst_n, stb, ax, ay, az} = '0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_regs();
    t_single();
    t_reject();
    t_double();
    t_improved();
    give_verdict();
  end
endmodule : tde_top_bench
